// ---- hdl/ee_eeprom_dev.sv ----
/*
  EEPROM device end: two-wire slave command sequencer, page latch, array
  and self-timed program cycle.
  Assumes link_clk free-running well above the bus rate; scl, sda and
  write_inhibit_n are asynchronous pins.
*/
// Notes on behaviour
// - Write select acked, then two address bytes.
// - Inhibit high until address end: no data ack.
// - Byte write: one data byte, ack, STOP.
// - Up to 32 bytes, one row programmed.
// - Write increments low five address bits only.
// - Master avoids overfilling a row.
// - Program only on STOP in tenth slot.
// - Programming ignores all bus activity.
// - Select unacked while busy, acked after.
// - Master may poll with select until ack.
// - Array starts erased to all ones.
// - Read select acked, byte sent, counter increments.
// - Random read: dummy write then read select.
// - Both selects share upper seven bits.
// - Single read: master nacks, then STOP.
// - Master ack continues with next address.
// - Sequential read ends with nack, STOP.
// - Read counter wraps from top to zero.
// - No ack in ninth slot: standby.
// - Address bits above array size ignored.
// - Address sent high byte first.
`timescale 1ns/1ps
`include "ee_map.svh"
module ee_eeprom_dev #(
  parameter int AW = `EE_ADDR_BITS,
  parameter int PROG_CYCLES = `EE_PROG_CYCLES,
  parameter logic [6:0] SEL_CODE = `EE_SEL_CODE
) (
  input wire logic link_clk,        // Link sampling clock
  input wire logic arst_n,          // Async reset, active low
  ee_link_if.device link,           // Two-wire bus
  input wire logic write_inhibit_n, // High blocks writes
  output logic busy                 // Program cycle running
);
  import ee_pkg::*;

  localparam int PCW = $clog2(PROG_CYCLES + 1);
  localparam int PB = `EE_PAGE_BITS;

  logic [2:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q, pin_p_q;
  logic scl_f, sda_f, wc_f, scl_p, sda_p;
  logic start_ev, stop_ev, rise_ev, fall_ev;
  ee_dev_state_t state_q;
  ee_byte_kind_t kind_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q, ahi_q, rd_byte;
  logic [AW-1:0] addr_q;
  logic rw_q, inhibit_q, stop_ok_q, sda_oe_q, busy_q;
  logic [PCW-1:0] prog_cnt_q;
  logic [7:0] page_q [`EE_PAGE_BYTES];
  logic [`EE_PAGE_BYTES-1:0] pvalid_q;
  // Erased at delivery; an initialiser keeps the row writer the sole driver
  logic [7:0] mem [2**AW] = '{default: `EE_ERASED_BYTE};
  logic data_take;

  // Three-stage pin capture; first stage read only by second
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_q <= `EE_PIN_IDLE;
      pin_s2_q <= `EE_PIN_IDLE;
      pin_s3_q <= `EE_PIN_IDLE;
      pin_f_q <= `EE_PIN_IDLE;
      pin_p_q <= `EE_PIN_IDLE;
    end else begin
      pin_s1_q <= {link.scl, link.sda, write_inhibit_n};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q <= ee_filter(pin_s2_q, pin_s3_q, pin_f_q);
      pin_p_q <= pin_f_q;
    end
  end

  assign scl_f = pin_f_q[2];
  assign sda_f = pin_f_q[1];
  assign wc_f = pin_f_q[0];
  assign scl_p = pin_p_q[2];
  assign sda_p = pin_p_q[1];

  // Bus conditions on filtered levels
  assign start_ev = scl_f & scl_p & sda_p & ~sda_f;
  assign stop_ev = scl_f & scl_p & ~sda_p & sda_f;
  assign rise_ev = scl_f & ~scl_p;
  assign fall_ev = ~scl_f & scl_p;

  // Async array read feeds the shifter at load time
  assign rd_byte = mem[addr_q];

  // Data byte accepted into the page latch
  assign data_take = (state_q == ES_RX) && fall_ev && (cnt_q == `EE_BYTE_BITS) &&
                     (kind_q == BK_DATA) && !inhibit_q && !start_ev && !stop_ev;

  // Main sequencer: bit counting, acks, address counter, program timer
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ES_IDLE;
      kind_q <= BK_SEL;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ahi_q <= 8'h00;
      addr_q <= '0;
      rw_q <= 1'b0;
      stop_ok_q <= 1'b0;
      sda_oe_q <= 1'b0;
      prog_cnt_q <= '0;
    end else if (state_q == ES_BUSY) begin
      // Bus fully ignored, so select polls go unanswered
      sda_oe_q <= 1'b0;
      prog_cnt_q <= prog_cnt_q + PCW'(1);
      if (prog_cnt_q == PCW'(PROG_CYCLES - 1)) begin
        state_q <= ES_IDLE;
      end
    end else if (start_ev) begin
      // Start or repeated start always begins a select byte
      state_q <= ES_RX;
      kind_q <= BK_SEL;
      cnt_q <= 4'h0;
      sda_oe_q <= 1'b0;
      stop_ok_q <= 1'b0;
    end else if (stop_ev) begin
      sda_oe_q <= 1'b0;
      prog_cnt_q <= '0;
      // Only a stop in the slot after a data ack programs
      if (stop_ok_q && (|pvalid_q) && state_q == ES_RX) begin
        state_q <= ES_BUSY;
      end else begin
        state_q <= ES_IDLE;
      end
    end else if (state_q != ES_IDLE && rise_ev) begin
      cnt_q <= cnt_q + 4'h1;
      if (state_q == ES_RX && cnt_q < `EE_BYTE_BITS) begin
        sh_q <= {sh_q[6:0], sda_f};
      end
      // Master ack sampled in ninth slot; high means done
      if (state_q == ES_TX && cnt_q == `EE_BYTE_BITS && sda_f) begin
        state_q <= ES_IDLE;
      end
    end else if (state_q != ES_IDLE && fall_ev) begin
      stop_ok_q <= 1'b0;
      if (cnt_q == `EE_BYTE_BITS) begin
        if (state_q == ES_TX) begin
          sda_oe_q <= 1'b0; // Release for master ack
        end else begin
          case (kind_q)
            BK_SEL: begin
              // Silent unless select code matches
              if (sh_q[7:1] == SEL_CODE) begin
                sda_oe_q <= 1'b1;
                rw_q <= sh_q[0];
              end else begin
                state_q <= ES_IDLE;
              end
            end
            BK_AHI: begin
              sda_oe_q <= 1'b1;
              ahi_q <= sh_q;
            end
            BK_ALO: begin
              sda_oe_q <= 1'b1;
              // Top bits beyond the array are dropped
              addr_q <= AW'({ahi_q, sh_q});
            end
            default: begin
              sda_oe_q <= !inhibit_q;
            end
          endcase
        end
      end else if (cnt_q == `EE_ACK_DONE) begin
        cnt_q <= 4'h0;
        if (state_q == ES_TX || (kind_q == BK_SEL && rw_q)) begin
          // Next byte out, counter moves on and wraps
          state_q <= ES_TX;
          sh_q <= rd_byte;
          sda_oe_q <= ~rd_byte[7];
          addr_q <= addr_q + AW'(1);
        end else begin
          sda_oe_q <= 1'b0;
          case (kind_q)
            BK_SEL: kind_q <= BK_AHI;
            BK_AHI: kind_q <= BK_ALO;
            BK_ALO: kind_q <= BK_DATA;
            default: begin
              // Row wrap: only the low bits count
              addr_q[PB-1:0] <= addr_q[PB-1:0] + PB'(1);
              stop_ok_q <= sda_oe_q; // Tenth slot opens
            end
          endcase
        end
      end else if (state_q == ES_TX) begin
        sh_q <= {sh_q[6:0], 1'b0};
        sda_oe_q <= ~sh_q[6];
      end
    end
  end

  // Write inhibit sampled from start to end of address
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      inhibit_q <= 1'b0;
    end else if (state_q != ES_BUSY && start_ev) begin
      inhibit_q <= wc_f;
    end else if (state_q == ES_RX && kind_q != BK_DATA && wc_f) begin
      inhibit_q <= 1'b1;
    end
  end

  // Page latch: bytes gather here until the program cycle
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      pvalid_q <= '0;
    end else if (state_q != ES_BUSY && start_ev) begin
      pvalid_q <= '0;
    end else if (data_take) begin
      pvalid_q[addr_q[PB-1:0]] <= 1'b1;
    end else if (state_q == ES_BUSY && prog_cnt_q == PCW'(PROG_CYCLES - 1)) begin
      pvalid_q <= '0;
    end
  end

  // Latch data has no reset; validity bits guard it
  always_ff @(posedge link_clk) begin
    if (data_take) begin
      page_q[addr_q[PB-1:0]] <= sh_q;
    end
  end

  // Program the latched bytes of the row, one byte per cycle, early in the busy time
  always_ff @(posedge link_clk) begin
    if (state_q == ES_BUSY && prog_cnt_q < PCW'(`EE_PAGE_BYTES) &&
        pvalid_q[prog_cnt_q[PB-1:0]]) begin
      mem[{addr_q[AW-1:PB], prog_cnt_q[PB-1:0]}] <= page_q[prog_cnt_q[PB-1:0]];
    end
  end

  // Busy flag for the user side
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_q == ES_BUSY);
    end
  end

  assign busy = busy_q;
  assign link.sda_d_oe = sda_oe_q;
  // Open drain: only ever pulls low
  assign link.sda_d_o = 1'b0;

endmodule : ee_eeprom_dev

// ---- hdl/ee_eeprom_host.sv ----
/*
  Host end: two-wire master that runs write, random read, current read
  and ack-poll commands. Makes scl from mclk by a divider.
  Assumes one command at a time from the user side.
*/
`timescale 1ns/1ps
`include "ee_map.svh"
module ee_eeprom_host #(
  parameter int QTR = `EE_QTR_CYCLES,
  parameter logic [6:0] SEL_CODE = `EE_SEL_CODE
) (
  input wire logic mclk,            // 25 MHz clock
  input wire logic arst_n,          // Async reset, active low
  ee_link_if.host link,             // Two-wire bus
  input wire logic cmd_valid,       // Command offered
  output logic cmd_ready,           // Idle, command taken
  input wire ee_pkg::ee_op_t cmd_op, // Command kind
  input wire logic [15:0] cmd_addr, // Byte address
  input wire logic [7:0] cmd_len,   // Byte count, 0 treated as 1
  input wire logic [7:0] wr_data,   // Next write byte
  output logic wr_take,             // Pulse: wr_data consumed
  output logic [7:0] rd_data,       // Read byte
  output logic rd_valid,            // Pulse: rd_data new
  output logic done,                // Pulse: command finished
  output logic nack                 // Last command saw a nack
);
  import ee_pkg::*;

  localparam int QW = $clog2(QTR + 1);

  logic [2:0] s_q;
  logic sda_f_q;
  logic [QW-1:0] div_q;
  logic [1:0] qtr_q;
  logic tick;
  ee_host_state_t st_q;
  ee_step_t step_q;
  ee_op_t op_q;
  logic [15:0] addr_q;
  logic [7:0] left_q, sh_q, rx_q;
  logic [3:0] bit_q;
  logic ackbit_q, scl_q, oe_q, retry_q;
  logic cmd_ready_q, wr_take_q, rd_valid_q, done_q, nack_q;
  logic [7:0] rd_data_q;

  // Data line comes from the device side: three stages, agreement filter
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= 3'h7;
      sda_f_q <= 1'b1;
    end else begin
      s_q <= {s_q[1:0], link.sda};
      sda_f_q <= (s_q[1] == s_q[2]) ? s_q[2] : sda_f_q;
    end
  end

  // Quarter-bit divider; restarts with each command
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= '0;
      qtr_q <= 2'h0;
    end else if (st_q == HS_IDLE || tick) begin
      div_q <= '0;
      qtr_q <= (st_q == HS_IDLE) ? 2'h0 : qtr_q + 2'h1;
    end else begin
      div_q <= div_q + QW'(1);
    end
  end

  assign tick = (div_q == QW'(QTR - 1));

  // Command sequencer and bit engine
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= HS_IDLE;
      step_q <= SP_SELW;
      op_q <= OP_WRITE;
      addr_q <= 16'h0000;
      left_q <= 8'h00;
      sh_q <= 8'h00;
      rx_q <= 8'h00;
      bit_q <= 4'h0;
      ackbit_q <= 1'b1;
      scl_q <= 1'b1;
      oe_q <= 1'b0;
      retry_q <= 1'b0;
      cmd_ready_q <= 1'b1;
      wr_take_q <= 1'b0;
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      wr_take_q <= 1'b0;
      rd_valid_q <= 1'b0;
      done_q <= 1'b0;
      case (st_q)
        HS_IDLE: begin
          if (cmd_valid && cmd_ready_q) begin
            cmd_ready_q <= 1'b0;
            op_q <= cmd_op;
            addr_q <= cmd_addr;
            left_q <= (cmd_len == 8'h00) ? 8'h01 : cmd_len;
            nack_q <= 1'b0;
            st_q <= HS_START;
            // Current read skips the address header
            step_q <= (cmd_op == OP_READ_CURRENT) ? SP_SELR : SP_SELW;
            sh_q <= {SEL_CODE, cmd_op == OP_READ_CURRENT};
          end
        end
        HS_START: if (tick) begin
          // Data falls while clock high
          case (qtr_q)
            2'h0: oe_q <= 1'b0;
            2'h1: scl_q <= 1'b1;
            2'h2: oe_q <= 1'b1;
            default: begin
              scl_q <= 1'b0;
              st_q <= HS_BIT;
              bit_q <= 4'h0;
            end
          endcase
        end
        HS_BIT: if (tick) begin
          case (qtr_q)
            2'h0: begin
              if (step_q == SP_RDAT) begin
                // Ack every byte but the last
                oe_q <= (bit_q == `EE_BYTE_BITS) && (left_q > 8'h01);
              end else begin
                oe_q <= (bit_q < `EE_BYTE_BITS) && !sh_q[7];
              end
            end
            2'h1: scl_q <= 1'b1;
            2'h2: begin
              if (bit_q < `EE_BYTE_BITS) begin
                rx_q <= {rx_q[6:0], sda_f_q};
              end else begin
                ackbit_q <= sda_f_q;
              end
            end
            default: begin
              scl_q <= 1'b0;
              if (bit_q < `EE_BYTE_BITS) begin
                bit_q <= bit_q + 4'h1;
                sh_q <= {sh_q[6:0], 1'b0};
              end else begin
                bit_q <= 4'h0;
                if (step_q == SP_RDAT) begin
                  rd_data_q <= rx_q;
                  rd_valid_q <= 1'b1;
                  left_q <= left_q - 8'h01;
                  if (left_q == 8'h01) begin
                    st_q <= HS_STOP;
                  end
                end else if (ackbit_q) begin
                  // Busy device: a poll retries the select
                  st_q <= HS_STOP;
                  retry_q <= (op_q == OP_POLL) && (step_q == SP_SELW);
                  nack_q <= (op_q != OP_POLL);
                end else begin
                  case (step_q)
                    SP_SELW: begin
                      if (op_q == OP_POLL) begin
                        st_q <= HS_STOP;
                      end else begin
                        step_q <= SP_AHI;
                        sh_q <= addr_q[15:8];
                      end
                    end
                    SP_AHI: begin
                      step_q <= SP_ALO;
                      sh_q <= addr_q[7:0];
                    end
                    SP_ALO: begin
                      if (op_q == OP_WRITE) begin
                        step_q <= SP_WDAT;
                        sh_q <= wr_data;
                        wr_take_q <= 1'b1;
                      end else begin
                        // Same select code, read direction
                        step_q <= SP_SELR;
                        sh_q <= {SEL_CODE, 1'b1};
                        st_q <= HS_START;
                      end
                    end
                    SP_WDAT: begin
                      left_q <= left_q - 8'h01;
                      if (left_q == 8'h01) begin
                        st_q <= HS_STOP;
                      end else begin
                        sh_q <= wr_data;
                        wr_take_q <= 1'b1;
                      end
                    end
                    default: step_q <= SP_RDAT;
                  endcase
                end
              end
            end
          endcase
        end
        default: if (tick) begin
          // Stop: data rises while clock high
          case (qtr_q)
            2'h0: oe_q <= 1'b1;
            2'h1: scl_q <= 1'b1;
            2'h2: oe_q <= 1'b0;
            default: begin
              retry_q <= 1'b0;
              if (retry_q) begin
                st_q <= HS_START;
                step_q <= SP_SELW;
                sh_q <= {SEL_CODE, 1'b0};
              end else begin
                st_q <= HS_IDLE;
                done_q <= 1'b1;
                cmd_ready_q <= 1'b1;
              end
            end
          endcase
        end
      endcase
    end
  end

  assign link.scl = scl_q;
  assign link.sda_m_oe = oe_q;
  // Open drain: only ever pulls low
  assign link.sda_m_o = 1'b0;
  assign cmd_ready = cmd_ready_q;
  assign wr_take = wr_take_q;
  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign done = done_q;
  assign nack = nack_q;

endmodule : ee_eeprom_host

// ---- hdl/ee_link_if.sv ----
/*
  The two-wire link between host and EEPROM device.
  Assumes both ends drive sda open-drain; scl comes only from the host.
*/
`timescale 1ns/1ps
interface ee_link_if;
  logic scl;      // Bus clock, driven by host
  logic sda;      // Resolved data line level
  logic sda_m_o;  // Host data value (always low)
  logic sda_m_oe; // Host pulls sda
  logic sda_d_o;  // Device data value (always low)
  logic sda_d_oe; // Device pulls sda

  // Wired-and with pull-up
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_d_oe & ~sda_d_o));

  modport host (output scl, output sda_m_o, output sda_m_oe, input sda);
  modport device (input scl, output sda_d_o, output sda_d_oe, input sda);
endinterface : ee_link_if

// ---- hdl/ee_map.svh ----
/*
  Constants of the two-wire EEPROM link: array geometry, select code,
  program time and bit timing. Assumes a 25 MHz host clock and a 32 ns
  device link clock.
*/
`ifndef EE_MAP_SVH
`define EE_MAP_SVH

// Array geometry
`define EE_ADDR_BITS 13
`define EE_PAGE_BITS 5
`define EE_PAGE_BYTES 32
`define EE_ERASED_BYTE 8'hff

// Select code, arbitrary value
`define EE_SEL_CODE 7'h2a

// Bit slots within one byte frame
`define EE_BYTE_BITS 4'h8
`define EE_ACK_DONE 4'h9

// Pins idle high: scl, sda, write_inhibit_n
`define EE_PIN_IDLE 3'h7

// Program cycle, longest time rounds down
`define EE_PROG_TIME_NS 10000000
`define EE_LINK_PERIOD_NS 32
`define EE_PROG_CYCLES (`EE_PROG_TIME_NS / `EE_LINK_PERIOD_NS)

// Bus clock from host divider, quarter bit rounds up
`define EE_MCLK_PERIOD_NS 40
`define EE_SCL_PERIOD_NS 2500
`define EE_QTR_CYCLES ((`EE_SCL_PERIOD_NS / 4 + `EE_MCLK_PERIOD_NS - 1) / `EE_MCLK_PERIOD_NS)

`endif

// ---- hdl/ee_pkg.sv ----
/*
  Types shared by both ends of the EEPROM link, and the pin filter.
  Assumes ee_map.svh for numbers.
*/
package ee_pkg;

  // Device sequencer states
  typedef enum logic [1:0] {ES_IDLE, ES_RX, ES_TX, ES_BUSY} ee_dev_state_t;

  // Which byte of a write command is being received
  typedef enum logic [1:0] {BK_SEL, BK_AHI, BK_ALO, BK_DATA} ee_byte_kind_t;

  // Host commands
  typedef enum logic [1:0] {OP_WRITE, OP_READ_RANDOM, OP_READ_CURRENT, OP_POLL} ee_op_t;

  // Host bus actions
  typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} ee_host_state_t;

  // Host position within a command
  typedef enum logic [2:0] {SP_SELW, SP_AHI, SP_ALO, SP_WDAT, SP_SELR, SP_RDAT} ee_step_t;

  // Accept a new level once second and third stages agree
  function automatic logic [2:0] ee_filter(input logic [2:0] s2, input logic [2:0] s3,
                                           input logic [2:0] held);
    ee_filter = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & held);
  endfunction : ee_filter

endpackage : ee_pkg

// ---- test/ee_link_monitor.sv ----
/*
  Checker on the two-wire link and the device busy flag.
  Assumes host scl timing from QTR and a program time of PROG link cycles.
*/
`timescale 1ns/1ps
module ee_link_monitor #(
  parameter int QTR = 16,
  parameter int PROG = 64
) (
  input wire logic mclk,            // Host clock
  input wire logic link_clk,        // Device clock
  input wire logic arst_n,          // Reset, active low
  input wire logic scl,             // Bus clock
  input wire logic sda,             // Resolved data
  input wire logic sda_m_oe,        // Host pulls sda
  input wire logic sda_d_oe,        // Device pulls sda
  input wire logic busy,            // Program cycle
  input wire logic write_inhibit_n  // Write block pin
);
  int hi_cnt;
  int busy_cnt;
  int stop_age;

  // Length of each scl high phase
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) hi_cnt <= 0;
    else hi_cnt <= scl ? hi_cnt + 1 : 0;
  end

  // Busy length, and age of the last STOP saturating at 255
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) busy_cnt <= 0;
    else busy_cnt <= busy ? busy_cnt + 1 : 0;
  end
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) stop_age <= 255;
    else if (scl && $past(scl) && $rose(sda)) stop_age <= 0;
    else if (stop_age < 255) stop_age <= stop_age + 1;
  end

  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence

  a_dev_drive_low: assert property (@(posedge link_clk) disable iff (!arst_n)
    $changed(sda_d_oe) |-> !scl) else $error("device changed sda with scl high");
  a_start_by_host: assert property (@(posedge mclk) disable iff (!arst_n)
    s_start |-> $rose(sda_m_oe) && !sda_d_oe) else $error("bad START");
  a_stop_released: assert property (@(posedge mclk) disable iff (!arst_n)
    s_stop |-> $fell(sda_m_oe) && !sda_d_oe) else $error("device held sda at STOP");
  a_scl_high_len: assert property (@(posedge mclk) disable iff (!arst_n)
    $fell(scl) |-> hi_cnt >= 2 * QTR) else $error("scl high too short");
  a_busy_silent: assert property (@(posedge link_clk) disable iff (!arst_n)
    busy |-> !sda_d_oe) else $error("device answered while busy");
  a_prog_on_stop: assert property (@(posedge link_clk) disable iff (!arst_n)
    $rose(busy) |-> stop_age < 16) else $error("program started without STOP");
  a_prog_length: assert property (@(posedge link_clk) disable iff (!arst_n)
    $fell(busy) |-> busy_cnt >= PROG - 1 && busy_cnt <= PROG + 1)
    else $error("program cycle length wrong");
  a_inhibit_no_prog: assert property (@(posedge link_clk) disable iff (!arst_n)
    $rose(busy) |-> !write_inhibit_n) else $error("program while inhibited");
endmodule : ee_link_monitor

// ---- test/test_i2c_eeprom_rw_sequencer.sv ----
/*
  Testbench: host and device joined by the link, driven through host commands.
  Assumes a short program time so ack polling completes quickly.
*/
`timescale 1ns/1ps
module test_i2c_eeprom_rw_sequencer;
  import ee_pkg::*;
  localparam int PROG = 2000;
  logic mclk, link_clk, arst_n, cmd_valid, cmd_ready, wr_take, rd_valid, done, nack;
  logic busy, write_inhibit_n;
  ee_op_t cmd_op;
  logic [15:0] cmd_addr;
  logic [7:0] cmd_len, wr_data, rd_data;
  logic [7:0] wbuf [0:7];
  logic [7:0] rbuf [$];
  int widx, n_errors, checks;
  ee_link_if lnk();
  ee_eeprom_host #(.QTR(16)) i_ee_eeprom_host (.mclk(mclk), .arst_n(arst_n), .link(lnk),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data),
    .rd_valid(rd_valid), .done(done), .nack(nack));
  ee_eeprom_dev #(.PROG_CYCLES(PROG)) i_ee_eeprom_dev (.link_clk(link_clk), .arst_n(arst_n),
    .link(lnk), .write_inhibit_n(write_inhibit_n), .busy(busy));
  ee_link_monitor #(.QTR(16), .PROG(PROG)) i_ee_link_monitor (.mclk(mclk),
    .link_clk(link_clk), .arst_n(arst_n), .scl(lnk.scl), .sda(lnk.sda),
    .sda_m_oe(lnk.sda_m_oe), .sda_d_oe(lnk.sda_d_oe), .busy(busy),
    .write_inhibit_n(write_inhibit_n));

  // Clocks with unrelated phase
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end

  // Next write byte on each take, read bytes collected
  always @(posedge mclk) begin
    if (wr_take === 1'b1) begin
      wr_data <= wbuf[widx + 1];
      widx <= widx + 1;
    end
    if (rd_valid === 1'b1) rbuf.push_back(rd_data);
  end

  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One command, bounded wait on done
  task cmd(input ee_op_t op, input logic [15:0] addr, input logic [7:0] len);
    int n;
    @(posedge mclk);
    cmd_op <= op;
    cmd_addr <= addr;
    cmd_len <= len;
    cmd_valid <= 1'b1;
    widx <= 0;
    wr_data <= wbuf[0];
    rbuf.delete();
    do @(posedge mclk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (done !== 1'b1 && n < 40000);
    chk("done", 8'h01, {7'h00, done});
  endtask : cmd

  task wrap_up();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  // Hang guard, over two and a half times the expected run
  initial begin
    #4000000;
    n_errors++;
    wrap_up();
  end

  initial begin
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = OP_WRITE;
    cmd_addr = 16'h0000;
    cmd_len = 8'h00;
    wr_data = 8'h00;
    write_inhibit_n = 1'b0;
    widx = 0;
    n_errors = 0;
    checks = 0;
    for (int i = 0; i < 8; i++) wbuf[i] = 8'ha0 + 8'(i);
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    cmd(OP_READ_RANDOM, 16'h0100, 8'h02);
    chk("erased0", 8'hff, rbuf[0]);
    chk("erased1", 8'hff, rbuf[1]);
    chk("nack", 8'h00, {7'h00, nack});
    $display("erased read test ends");
    cmd(OP_WRITE, 16'he01e, 8'h05);
    repeat (4) @(posedge mclk);
    chk("busy", 8'h01, {7'h00, busy});
    cmd(OP_POLL, 16'h0000, 8'h01);
    chk("poll busy", 8'h00, {7'h00, busy});
    repeat (100) @(posedge mclk);
    chk("poll prog", 8'h00, {7'h00, busy});
    cmd(OP_READ_RANDOM, 16'h201e, 8'h03);
    chk("row1e", 8'ha0, rbuf[0]);
    chk("row1f", 8'ha1, rbuf[1]);
    chk("next row", 8'hff, rbuf[2]);
    cmd(OP_READ_RANDOM, 16'h0000, 8'h02);
    chk("wrap00", 8'ha2, rbuf[0]);
    chk("wrap01", 8'ha3, rbuf[1]);
    cmd(OP_READ_CURRENT, 16'h0000, 8'h00);
    chk("current", 8'ha4, rbuf[0]);
    chk("one byte", 8'h01, 8'(rbuf.size()));
    cmd(OP_READ_RANDOM, 16'h1fff, 8'h02);
    chk("top", 8'hff, rbuf[0]);
    chk("roll", 8'ha2, rbuf[1]);
    $display("page and read test ends");
    write_inhibit_n <= 1'b1;
    wbuf[0] = 8'h5a;
    cmd(OP_WRITE, 16'h0040, 8'h01);
    chk("inh nack", 8'h01, {7'h00, nack});
    repeat (100) @(posedge mclk);
    chk("inh busy", 8'h00, {7'h00, busy});
    write_inhibit_n <= 1'b0;
    cmd(OP_READ_RANDOM, 16'h0040, 8'h01);
    chk("inh kept", 8'hff, rbuf[0]);
    cmd(OP_WRITE, 16'h0040, 8'h01);
    chk("byte nack", 8'h00, {7'h00, nack});
    cmd(OP_POLL, 16'h0000, 8'h01);
    cmd(OP_READ_RANDOM, 16'h0040, 8'h01);
    chk("byte", 8'h5a, rbuf[0]);
    $display("inhibit test ends");
    wrap_up();
  end
endmodule : test_i2c_eeprom_rw_sequencer
